// *** pkg/addr_ext_pkg.sv ***
// Package: constants and carrier types for the flash address extension.
// Assumes a command decoder upstream that classifies each opcode.
package addr_ext_pkg;

	localparam int LEGACY_ADDR_BITS = 24;
	localparam int FULL_ADDR_BITS = 32;
	localparam int BANK_BITS = 8;
	localparam int EXT_MODE_BIT = 7;
	localparam int BANK_UPPER_BITS = FULL_ADDR_BITS - LEGACY_ADDR_BITS;
	localparam logic [BANK_BITS-1:0] BANK_RESET = 8'h00;
	localparam logic [5:0] LEGACY_ADDR_LEN = 6'h18;
	localparam logic [5:0] FULL_ADDR_LEN = 6'h20;
	localparam logic [FULL_ADDR_BITS-1:0] ADDR_ZERO = 32'h0000_0000;

	// Command classes as seen by the address path
	typedef enum logic [1:0]
	{
		CMD_LEGACY,
		CMD_NEW32,
		CMD_OTHER_SPACE,
		CMD_NO_ADDR
	} cmd_class_type;

	// One finished address phase
	typedef struct packed
	{
		logic [FULL_ADDR_BITS-1:0] addr;
		logic main_array;
		logic valid;
	} addr_out_type;

endpackage : addr_ext_pkg

// *** core/addr_shift_in.sv ***
// Serial address collector: shifts in a chosen number of address bits.
// Assumes bits arrive MSB first, one per clock with bit_valid high.
module addr_shift_in
	import addr_ext_pkg::*;
(
	input wire logic ref_clk,
	input wire logic nrst,
	input wire logic start,
	input wire logic [5:0] len,
	input wire logic bit_valid,
	input wire logic bit_in,
	output logic done,
	output logic [FULL_ADDR_BITS-1:0] value
);

	logic [5:0] cnt_q;
	logic [5:0] cnt_d;
	logic [FULL_ADDR_BITS-1:0] sh_q;
	logic [FULL_ADDR_BITS-1:0] sh_d;
	logic done_q;
	wire logic active;
	wire logic last;

	assign active = cnt_q != 6'h00;
	assign last = active && bit_valid && cnt_q == 6'h01;
	assign cnt_d = start ? len :
		(active && bit_valid) ? cnt_q - 6'h01 : cnt_q;
	assign sh_d = start ? ADDR_ZERO :
		(active && bit_valid) ? {sh_q[FULL_ADDR_BITS-2:0], bit_in} : sh_q;

	always_ff @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			cnt_q <= 6'h00;
			sh_q <= ADDR_ZERO;
			done_q <= 1'b0;
		end
		else
		begin
			cnt_q <= cnt_d;
			sh_q <= sh_d;
			done_q <= last;
		end
	end

	assign done = done_q;
	assign value = sh_q;

endmodule : addr_shift_in

// *** core/flash_address_extension.sv ***
// Flash address extension: forms the array byte address from the
// serially received address and the bank register.
// Assumes a decoder on the same clock that classifies the command and
// marks where the address phase starts.
module flash_address_extension
	import addr_ext_pkg::*;
(
	input wire logic ref_clk,
	input wire logic nrst,
	input wire logic addr_start,
	input wire cmd_class_type cmd_class,
	input wire logic addr_bit_valid,
	input wire logic addr_bit,
	input wire logic bank_wr,
	input wire logic [BANK_BITS-1:0] bank_wr_data,
	output addr_out_type addr_out,
	output logic [BANK_BITS-1:0] bank_value,
	output logic ext_mode,
	output logic [5:0] addr_len_cur
);

	typedef enum logic [1:0]
	{
		ST_IDLE,
		ST_SHIFT
	} state_type;

	state_type state_q;
	state_type state_d;
	logic [BANK_BITS-1:0] bank_q;
	logic [BANK_BITS-1:0] bank_d;
	cmd_class_type class_q;
	cmd_class_type class_d;
	logic used_bank_q;
	logic used_bank_d;
	logic [5:0] len_q;
	logic [5:0] len_d;
	addr_out_type out_q;
	addr_out_type out_d;
	wire logic ext_mode_w;
	wire logic needs_full;
	wire logic take_start;
	wire logic [5:0] len_sel;
	wire logic shift_done;
	wire logic [FULL_ADDR_BITS-1:0] shift_value;
	wire logic [FULL_ADDR_BITS-1:0] formed_addr;
	wire logic [BANK_UPPER_BITS-1:0] bank_upper;
	logic [BANK_UPPER_BITS-1:0] upper_q;
	logic [BANK_UPPER_BITS-1:0] upper_d;
	wire logic is_legacy;
	wire logic is_new32;
	wire logic is_other_space;
	wire logic is_addressed;
	wire logic bank_load;
	wire logic main_array_w;

	assign ext_mode_w = bank_q[EXT_MODE_BIT];
	// Command classes as seen by the address path
	assign is_legacy = cmd_class == CMD_LEGACY;
	assign is_new32 = cmd_class == CMD_NEW32;
	assign is_other_space = cmd_class == CMD_OTHER_SPACE;
	assign is_addressed = cmd_class != CMD_NO_ADDR;

	// New codes and separate spaces ignore the mode bit
	assign needs_full = is_new32 ||
		is_other_space ||
		(is_legacy && ext_mode_w);
	assign len_sel = needs_full ? FULL_ADDR_LEN : LEGACY_ADDR_LEN;
	// Address-less commands never open a phase
	assign take_start = state_q == ST_IDLE && addr_start && is_addressed;

	// Bank bits below the extended-mode flag are the upper address
	assign bank_upper = {1'b0, bank_q[BANK_UPPER_BITS-2:0]};
	// Upper bits frozen at start so a later write cannot split an access
	assign upper_d = take_start ? bank_upper : upper_q;

	// Received 24 bits alone stay below 16 Mbytes; bank widens them
	assign formed_addr = used_bank_q ?
		{upper_q, shift_value[LEGACY_ADDR_BITS-1:0]} :
		shift_value;
	assign main_array_w = class_q != CMD_OTHER_SPACE;

	always_comb
	begin
		state_d = state_q;
		class_d = class_q;
		used_bank_d = used_bank_q;
		len_d = len_q;
		out_d = out_q;
		out_d.valid = 1'b0;
		case (state_q)
			ST_IDLE:
			begin
				if (take_start)
				begin
					state_d = ST_SHIFT;
					class_d = cmd_class;
					used_bank_d = !needs_full;
					len_d = len_sel;
				end
			end
			ST_SHIFT:
			begin
				if (shift_done)
				begin
					state_d = ST_IDLE;
					out_d.addr = formed_addr;
					out_d.main_array = main_array_w;
					out_d.valid = 1'b1;
				end
			end
			default:
			begin
				state_d = ST_IDLE;
			end
		endcase
	end

	// Bank loads only between address phases so an access keeps its bank
	assign bank_load = bank_wr && state_q == ST_IDLE;
	assign bank_d = bank_load ? bank_wr_data : bank_q;

	addr_shift_in u_shift
	(
		.ref_clk(ref_clk),
		.nrst(nrst),
		.start(take_start),
		.len(len_sel),
		.bit_valid(addr_bit_valid),
		.bit_in(addr_bit),
		.done(shift_done),
		.value(shift_value)
	);

	always_ff @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			state_q <= ST_IDLE;
		end
		else
		begin
			state_q <= state_d;
		end
	end

	// Reset clears bank and mode bit, so legacy accesses start at zero
	always_ff @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			bank_q <= BANK_RESET;
		end
		else
		begin
			bank_q <= bank_d;
		end
	end

	always_ff @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			class_q <= CMD_NO_ADDR;
		end
		else
		begin
			class_q <= class_d;
		end
	end

	always_ff @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			used_bank_q <= 1'b0;
		end
		else
		begin
			used_bank_q <= used_bank_d;
		end
	end

	always_ff @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			len_q <= LEGACY_ADDR_LEN;
		end
		else
		begin
			len_q <= len_d;
		end
	end

	always_ff @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			out_q <= '0;
		end
		else
		begin
			out_q <= out_d;
		end
	end

	always_ff @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			upper_q <= '0;
		end
		else
		begin
			upper_q <= upper_d;
		end
	end

	assign addr_out = out_q;
	assign bank_value = bank_q;
	assign ext_mode = bank_q[EXT_MODE_BIT];
	assign addr_len_cur = len_q;

endmodule : flash_address_extension

// *** dv/flash_address_extension_sva.sv ***
// Checker: port assertions for the address extension block.
// Assumes no bank write while an address phase runs.
module flash_address_extension_sva
	import addr_ext_pkg::*;
(
	input wire logic ref_clk,
	input wire logic nrst,
	input wire logic addr_start,
	input wire cmd_class_type cmd_class,
	input wire logic bank_wr,
	input wire logic [BANK_BITS-1:0] bank_wr_data,
	input wire addr_out_type addr_out,
	input wire logic [BANK_BITS-1:0] bank_value,
	input wire logic ext_mode,
	input wire logic [5:0] addr_len_cur
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!nrst);
	reset_clear_a: assert property ($rose(nrst) |-> !bank_value)
		else $error("bank not cleared");
	mode_bit_a: assert property (!bank_wr |=> $stable(ext_mode))
		else $error("mode bit changed");
	legacy_len_a: assert property (addr_start
		&& cmd_class == CMD_LEGACY
		|=> addr_len_cur == ($past(ext_mode) ? FULL_ADDR_LEN : LEGACY_ADDR_LEN))
		else $error("legacy length wrong");
	new_len_a: assert property (addr_start && cmd_class == CMD_NEW32
		|=> addr_len_cur == FULL_ADDR_LEN) else $error("new length wrong");
	space_len_a: assert property (addr_start
		&& cmd_class == CMD_OTHER_SPACE
		|=> ##33 addr_out.valid && !addr_out.main_array)
		else $error("other space wrong");
	upper_bank_a: assert property (addr_out.valid
		&& addr_len_cur == LEGACY_ADDR_LEN
		|-> addr_out.addr[31:24] == {1'b0, bank_value[6:0]})
		else $error("upper bits wrong");
	bank_load_a: assert property (bank_wr && !addr_start
		|=> bank_value == $past(bank_wr_data)) else $error("bank not loaded");
	legacy_time_a: assert property (addr_start
		&& cmd_class == CMD_LEGACY
		&& !ext_mode |-> ##26 addr_out.valid) else $error("short phase late");
endmodule : flash_address_extension_sva

bind flash_address_extension flash_address_extension_sva chk
(
	.ref_clk, .nrst, .addr_start, .cmd_class, .bank_wr, .bank_wr_data,
	.addr_out, .bank_value, .ext_mode, .addr_len_cur
);

// *** dv/host_model.sv ***
// Host model: sends one serial address phase on request.
// Assumes the caller waits for each result.
module host_model
	import addr_ext_pkg::*;
(
	input wire logic ref_clk,
	output cmd_class_type cmd_class,
	output logic addr_start,
	output logic addr_bit_valid,
	output logic addr_bit
);
	timeunit 1ns;
	timeprecision 1ps;
	initial
	begin
		cmd_class = CMD_NO_ADDR;
		addr_start = 1'b0;
		addr_bit_valid = 1'b0;
		addr_bit = 1'b0;
	end
	task automatic send(cmd_class_type c, logic [31:0] a, int n);
		@(posedge ref_clk) #1;
		cmd_class = c;
		addr_start = 1'b1;
		for (int i = n - 1; i >= 0; i--)
		begin
			@(posedge ref_clk) #1;
			addr_start = 1'b0;
			addr_bit_valid = 1'b1;
			addr_bit = a[i];
		end
		@(posedge ref_clk) #1;
		addr_bit_valid = 1'b0;
		// Released line must not show a stale bit
		addr_bit = ~addr_bit;
	endtask : send
endmodule : host_model

// *** dv/flash_address_extension_tb.sv ***
// Bench: random address phases against a behavioural model.
// Assumes the host model sends bits MSB first.
module flash_address_extension_tb
	import addr_ext_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic ref_clk = 1'b0;
	logic nrst = 1'b0;
	logic bank_wr = 1'b0;
	logic [7:0] bank_wr_data = 8'h00;
	logic addr_start, addr_bit_valid, addr_bit, ext_mode;
	cmd_class_type cmd_class;
	addr_out_type addr_out;
	logic [7:0] bank_value;
	logic [5:0] addr_len_cur;
	logic [7:0] bank = 8'h00;
	logic [31:0] a;
	int fails = 0;
	int n_tests = 0;
	int seed = 32'h6641_25bd;
	always #5 ref_clk = ~ref_clk;
	host_model host (.ref_clk, .cmd_class, .addr_start, .addr_bit_valid,
		.addr_bit);
	flash_address_extension dut (.ref_clk, .nrst, .addr_start, .cmd_class,
		.addr_bit_valid, .addr_bit, .bank_wr, .bank_wr_data, .addr_out,
		.bank_value, .ext_mode, .addr_len_cur);
	task automatic chk(string s, logic [31:0] x, logic [31:0] g);
		n_tests++;
		if (g !== x)
		begin
			fails++;
			$display("Error %s expected %h seen %h", s, x, g);
		end
	endtask : chk
	task automatic conclude();
		if (fails == 0 && n_tests > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : conclude
	task automatic wbank(logic [7:0] v);
		@(posedge ref_clk) #1;
		bank_wr = 1'b1;
		bank_wr_data = v;
		@(posedge ref_clk) #1;
		bank_wr = 1'b0;
		bank = v;
		chk("bank", v, bank_value);
		chk("mode", v[7], ext_mode);
	endtask : wbank
	task automatic xfer(cmd_class_type c);
		int n;
		logic [31:0] e;
		n = (c == CMD_LEGACY && !bank[7]) ? 24 : 32;
		a = $random(seed);
		host.send(c, a, n);
		for (int i = 0; i < 5 && addr_out.valid !== 1'b1; i++)
			@(posedge ref_clk) #1;
		chk("valid", 1, addr_out.valid);
		e = n == 24 ? {1'b0, bank[6:0], a[23:0]} : a;
		chk("addr", e, addr_out.addr);
		chk("array", c != CMD_OTHER_SPACE, addr_out.main_array);
		chk("length", n, addr_len_cur);
		if (fails > 0)
			conclude();
	endtask : xfer
	initial
	begin
		repeat (12) @(posedge ref_clk);
		#1 nrst = 1'b1;
		chk("length", 24, addr_len_cur);
		xfer(CMD_LEGACY);
		for (int k = 0; k < 4; k++)
		begin
			wbank({k[0], 7'($random(seed))});
			for (int c = 0; c < 3; c++)
				xfer(cmd_class_type'(c));
		end
		// An address-less command must never open a phase
		host.send(CMD_NO_ADDR, a, 24);
		for (int i = 0; i < 3; i++)
		begin
			chk("refused", 0, addr_out.valid);
			@(posedge ref_clk) #1;
		end
		@(posedge ref_clk) #1 nrst = 1'b0;
		bank = 8'h00;
		repeat (2) @(posedge ref_clk);
		#1 nrst = 1'b1;
		chk("bank", 0, bank_value);
		xfer(CMD_LEGACY);
		conclude();
	end
endmodule : flash_address_extension_tb
